// File: tws_consts.vh
// register offsets, field positions and reset values of the two-wire status block
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TWS_ADDR_W          8
`define TWS_OFF_STATUS      8'h20
`define TWS_OFF_IRQ_SET     8'h24
`define TWS_OFF_IRQ_CLR     8'h28
`define TWS_OFF_IRQ_MASK    8'h2C
`define TWS_OFF_RX_HOLD     8'h30
`define TWS_OFF_TX_HOLD     8'h34

// ----------------------------------------------------------------
// status and mask bit positions
// ----------------------------------------------------------------
`define TWS_B_TRANSFER_COMPLETE        0
`define TWS_B_RECEIVE_READY         1
`define TWS_B_TRANSMIT_READY         2
`define TWS_B_SLVREAD       3
`define TWS_B_SLVADDR       4
`define TWS_B_GCALL         5
`define TWS_B_OVERRUN       6
`define TWS_B_NOT_ACKNOWLEDGED          8
`define TWS_B_ARBLOST       9
`define TWS_B_STRETCH       10
`define TWS_B_SLVEND        11
`define TWS_B_RXDONE        12
`define TWS_B_TXDONE        13
`define TWS_B_RXALL         14
`define TWS_B_TXALL         15

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define TWS_FLAG_W          16
`define TWS_BYTE_W          8
`define TWS_STATUS_RESET    16'hF009
`define TWS_MASK_RESET      16'h0000
`define TWS_MASK_VALID      16'hFF77
`define TWS_STICKY_BITS     16'h0B60
`define TWS_HOLD_RESET      8'h00
`define TWS_ZERO_WORD       32'h00000000

`endif

// File: tws_status_irq.v
// status flags, interrupt mask and holding registers of a two-wire bus controller
`timescale 1ns/100ps
`include "tws_consts.vh"

// What this block does
// RULE1: master arbitration loss sets arbitration_lost and transfer_complete; status read clears it.
// RULE2: slave clock_stretch_wait is high while holding clock for unserviced holding register.
// RULE3: slave_access_end sets when slave_addressed falls, zero during access, read clears.
// RULE4: rx_count_done sets once rx count reaches zero since last count write; the code sets it in master mode only.
// RULE5: tx_count_done sets once tx count reaches zero since last count write; the code sets it in master mode only.
// RULE6: rx_buffers_all_done reads one only while both rx counters are zero; the code also requires master mode.
// RULE7: tx_buffers_all_done reads one only while both tx counters are zero; the code also requires master mode.
// RULE8: enable-set write sets mask bits written one, others unchanged.
// RULE9: enable-clear write clears mask bits written one, others unchanged.
// RULE10: mask view reads one per enabled source; all mask bits zero after reset.
// RULE11: set, clear and mask share one layout; bits 3 and 7 reserved.
// RULE12: receive holding register shows last received byte in bits 7..0, rest zero.
// RULE13: transmit holding register takes next byte to send in bits 7..0.
// RULE14: master transfer_complete low during frame, high after empty shifter and stop.
// RULE15: slave_addressed rises on address match, falls on not-acknowledge or stop.
// RULE16: interrupt output high while any flag is high with its mask bit set.
// RULE17: transfer counters come from the DMA channel; buffer flags derive combinationally.

module tws_status_irq #(
    parameter CNT_W = 16
) (
    input  wire                      hclk,
    input  wire                      hresetn,
    // ahb-lite slave
    input  wire                      hsel,
    input  wire [31:0]               haddr,
    input  wire [1:0]                htrans,
    input  wire                      hwrite,
    input  wire [2:0]                hsize,
    input  wire [31:0]               hwdata,
    input  wire                      hready,
    output wire                      hreadyout,
    output wire                      hresp,
    output reg  [31:0]               hrdata,
    // byte-level engine, same clock
    input  wire                      master_mode,
    input  wire                      frame_start,
    input  wire                      frame_done,
    input  wire                      arb_lost_event,
    input  wire                      not_acknowledged_event,
    input  wire                      rx_byte_valid,
    input  wire [7:0]                received_byte,
    input  wire                      tx_byte_taken,
    input  wire                      slave_read,
    input  wire                      addr_match,
    input  wire                      stop_or_not_acknowledged,
    input  wire                      general_call,
    output reg  [7:0]                byte_to_send,
    output wire                      tx_hold_written,
    output wire                      transmit_ready,
    // dma channel counters, same clock
    input  wire [CNT_W-1:0]          rx_transfer_count,
    input  wire [CNT_W-1:0]          rx_next_count,
    input  wire [CNT_W-1:0]          tx_transfer_count,
    input  wire [CNT_W-1:0]          tx_next_count,
    input  wire                      rx_count_written,
    input  wire                      tx_count_written,
    // bus clock pin and interrupt output
    input  wire                      scl_in,
    output wire                      scl_out,
    output wire                      scl_oe_n,
    output wire                      irq
);

    // ----------------------------------------------------------------
    // bus address and data phase
    // ----------------------------------------------------------------
    reg                         dp_valid;
    reg                         dp_write;
    reg  [`TWS_ADDR_W-1:0]      dp_addr;
    wire                        ap_take;
    wire                        ap_read;
    wire [`TWS_ADDR_W-1:0]      ap_addr;
    wire                        wr_now;

    // zero wait states: every register answers in the first data cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap_take   = hsel & htrans[1] & hready;
    assign ap_read   = ap_take & ~hwrite;
    assign ap_addr   = haddr[`TWS_ADDR_W-1:0];
    assign wr_now    = dp_valid & dp_write;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= {`TWS_ADDR_W{1'b0}};
        end else begin
            dp_valid <= ap_take;
            dp_write <= hwrite;
            dp_addr  <= ap_addr;
        end
    end

    wire        wr_status;
    wire        wr_irq_set;
    wire        wr_irq_clr;
    wire        wr_tx_hold;
    wire        rd_status;
    wire        rd_rx_hold;
    wire [15:0] w1c;
    wire [15:0] rclr;
    wire [15:0] clr;

    assign wr_status  = wr_now & (dp_addr == `TWS_OFF_STATUS);
    assign wr_irq_set = wr_now & (dp_addr == `TWS_OFF_IRQ_SET);
    assign wr_irq_clr = wr_now & (dp_addr == `TWS_OFF_IRQ_CLR);
    assign wr_tx_hold = wr_now & (dp_addr == `TWS_OFF_TX_HOLD);
    assign rd_status  = ap_read & (ap_addr == `TWS_OFF_STATUS);
    assign rd_rx_hold = ap_read & (ap_addr == `TWS_OFF_RX_HOLD);

    // write-one-to-clear of the sticky bits, alongside clear on read
    assign w1c  = wr_status ? (hwdata[15:0] & `TWS_STICKY_BITS) : 16'h0000;
    assign rclr = rd_status ? `TWS_STICKY_BITS : 16'h0000;
    assign clr  = w1c | rclr;

    // ----------------------------------------------------------------
    // clock pin synchroniser and edge
    // ----------------------------------------------------------------
    reg         scl_meta;
    reg         scl_sync;
    reg         scl_prev;
    wire        scl_fall;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
        end
    end

    assign scl_fall = scl_prev & ~scl_sync;

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    reg         transfer_complete;
    reg         receive_ready;
    reg         tx_ready;
    reg         slave_addressed;
    reg         general_call_seen;
    reg         overrun_error;
    reg         not_acknowledged;
    reg         arbitration_lost;
    reg         clock_stretch_wait;
    reg         slave_access_end;
    reg         rx_count_done;
    reg         tx_count_done;
    reg  [7:0]  rx_hold;
    wire        rx_buffers_all_done;
    wire        tx_buffers_all_done;
    wire        stretch_need;
    wire        slave_mode;
    wire        rx_cur_zero;
    wire        rx_nxt_zero;
    wire        tx_cur_zero;
    wire        tx_nxt_zero;
    wire        tc_set;
    wire        arb_set;
    wire        sa_set;
    wire        sa_fall;
    wire        gcall_set;
    wire        ovr_set;
    wire        rx_done_set;
    wire        tx_done_set;

    assign slave_mode     = ~master_mode;
    assign transmit_ready = tx_ready;

    // RULE17
    assign rx_cur_zero = (rx_transfer_count == {CNT_W{1'b0}});
    assign rx_nxt_zero = (rx_next_count == {CNT_W{1'b0}});
    assign tx_cur_zero = (tx_transfer_count == {CNT_W{1'b0}});
    assign tx_nxt_zero = (tx_next_count == {CNT_W{1'b0}});
    assign rx_buffers_all_done = master_mode & rx_cur_zero & rx_nxt_zero; // RULE6
    assign tx_buffers_all_done = master_mode & tx_cur_zero & tx_nxt_zero; // RULE7

    // set terms; each except rx_done_set and tx_done_set wins over its clear in the same cycle
    assign tc_set      = arb_set | frame_done;
    assign arb_set     = master_mode & arb_lost_event;
    assign sa_set      = slave_mode & addr_match;
    assign sa_fall     = slave_addressed & stop_or_not_acknowledged & ~sa_set;
    assign gcall_set   = slave_mode & general_call;
    assign ovr_set     = rx_byte_valid & receive_ready;
    assign rx_done_set = master_mode & rx_cur_zero;
    assign tx_done_set = master_mode & tx_cur_zero;

    // stretch while a slave byte boundary finds its holding register unserviced
    assign stretch_need = slave_mode & slave_addressed &
                          (slave_read ? tx_ready : receive_ready);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transfer_complete  <= 1'b1;
            receive_ready      <= 1'b0;
            tx_ready           <= 1'b0;
            slave_addressed    <= 1'b0;
            general_call_seen  <= 1'b0;
            overrun_error      <= 1'b0;
            not_acknowledged   <= 1'b0;
            arbitration_lost   <= 1'b0;
            clock_stretch_wait <= 1'b0;
            slave_access_end   <= 1'b0;
            rx_hold            <= `TWS_HOLD_RESET;
        end else begin
            // set wins over a clear in the same cycle, for every flag in this always block
            if (tc_set)
                transfer_complete <= 1'b1; // RULE1 RULE14
            else if (frame_start)
                transfer_complete <= 1'b0; // RULE14

            if (rx_byte_valid) begin
                receive_ready <= 1'b1;
                rx_hold       <= received_byte; // RULE12
            end else if (rd_rx_hold)
                receive_ready <= 1'b0;

            if (tx_byte_taken | not_acknowledged_event)
                tx_ready <= 1'b1;
            else if (wr_tx_hold)
                tx_ready <= 1'b0;

            if (sa_set)
                slave_addressed <= 1'b1; // RULE15
            else if (stop_or_not_acknowledged)
                slave_addressed <= 1'b0; // RULE15

            if (gcall_set)
                general_call_seen <= 1'b1;
            else if (clr[`TWS_B_GCALL])
                general_call_seen <= 1'b0;

            if (ovr_set)
                overrun_error <= 1'b1;
            else if (clr[`TWS_B_OVERRUN])
                overrun_error <= 1'b0;

            if (not_acknowledged_event)
                not_acknowledged <= 1'b1;
            else if (clr[`TWS_B_NOT_ACKNOWLEDGED])
                not_acknowledged <= 1'b0;

            if (arb_set)
                arbitration_lost <= 1'b1; // RULE1
            else if (clr[`TWS_B_ARBLOST])
                arbitration_lost <= 1'b0; // RULE1

            // held from the first falling edge after the need until serviced
            clock_stretch_wait <= stretch_need & (clock_stretch_wait | scl_fall); // RULE2

            if (sa_fall)
                slave_access_end <= 1'b1; // RULE3
            else if (slave_addressed | sa_set)
                slave_access_end <= 1'b0; // RULE3
            else if (clr[`TWS_B_SLVEND])
                slave_access_end <= 1'b0; // RULE3
        end
    end

    // counter flags stay set until software rewrites a count
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_count_done <= 1'b1;
            tx_count_done <= 1'b1;
        end else begin
            if (rx_count_written)
                rx_count_done <= 1'b0; // RULE4
            else if (rx_done_set)
                rx_count_done <= 1'b1; // RULE4

            if (tx_count_written)
                tx_count_done <= 1'b0; // RULE5
            else if (tx_done_set)
                tx_count_done <= 1'b1; // RULE5
        end
    end

    // ----------------------------------------------------------------
    // slave_access_end timing
    // ----------------------------------------------------------------
    // the set term reads slave_addressed still high in the falling cycle,
    // so the end flag rises in the same edge that drops slave_addressed

    // ----------------------------------------------------------------
    // clock pin drive
    // ----------------------------------------------------------------
    // only ever pulls low; the line is released otherwise
    assign scl_out  = 1'b0;
    assign scl_oe_n = ~clock_stretch_wait; // RULE2

    // ----------------------------------------------------------------
    // transmit holding register
    // ----------------------------------------------------------------
    assign tx_hold_written = wr_tx_hold;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            byte_to_send <= `TWS_HOLD_RESET;
        else if (wr_tx_hold)
            byte_to_send <= hwdata[7:0]; // RULE13
    end

    // ----------------------------------------------------------------
    // status word and mask
    // ----------------------------------------------------------------
    reg  [15:0] status_word;
    reg  [15:0] irq_mask;

    always @* begin
        status_word                  = 16'h0000;
        status_word[`TWS_B_TRANSFER_COMPLETE]   = transfer_complete;
        status_word[`TWS_B_RECEIVE_READY]    = receive_ready;
        status_word[`TWS_B_TRANSMIT_READY]    = tx_ready;
        status_word[`TWS_B_SLVREAD]  = slave_read;
        status_word[`TWS_B_SLVADDR]  = slave_addressed;
        status_word[`TWS_B_GCALL]    = general_call_seen;
        status_word[`TWS_B_OVERRUN]  = overrun_error;
        status_word[`TWS_B_NOT_ACKNOWLEDGED]     = not_acknowledged;
        status_word[`TWS_B_ARBLOST]  = arbitration_lost;
        status_word[`TWS_B_STRETCH]  = clock_stretch_wait;
        status_word[`TWS_B_SLVEND]   = slave_access_end;
        status_word[`TWS_B_RXDONE]   = rx_count_done;
        status_word[`TWS_B_TXDONE]   = tx_count_done;
        status_word[`TWS_B_RXALL]    = rx_buffers_all_done;
        status_word[`TWS_B_TXALL]    = tx_buffers_all_done;
    end

    // reserved bits 3 and 7 can never be enabled
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_mask <= `TWS_MASK_RESET; // RULE10
        else if (wr_irq_set)
            irq_mask <= irq_mask | (hwdata[15:0] & `TWS_MASK_VALID); // RULE8 RULE11
        else if (wr_irq_clr)
            irq_mask <= irq_mask & ~(hwdata[15:0] & `TWS_MASK_VALID); // RULE9 RULE11
    end

    assign irq = |(status_word & irq_mask); // RULE16

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    reg  [31:0] next_hrdata;

    always @* begin
        case (ap_addr)
            `TWS_OFF_STATUS:   next_hrdata = {16'h0000, status_word};
            `TWS_OFF_IRQ_MASK: next_hrdata = {16'h0000, irq_mask}; // RULE10
            `TWS_OFF_RX_HOLD:  next_hrdata = {24'h000000, rx_hold}; // RULE12
            `TWS_OFF_TX_HOLD:  next_hrdata = {24'h000000, byte_to_send};
            default:           next_hrdata = `TWS_ZERO_WORD;
        endcase
    end

    // data is captured at the address edge, together with any read clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= `TWS_ZERO_WORD;
        else if (ap_read)
            hrdata <= next_hrdata;
    end

endmodule

// File: tws_status_irq_assertions.sv
// port-level checker of the two-wire status block
`timescale 1ns/100ps
`include "tws_consts.vh"

module tws_sti_checker #(
    parameter CNT_W = 16
) (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        master_mode,
    input wire        rx_byte_valid,
    input wire [7:0]  received_byte,
    input wire        tx_byte_taken,
    input wire        not_acknowledged_event,
    input wire [7:0]  byte_to_send,
    input wire        tx_hold_written,
    input wire        transmit_ready,
    input wire        scl_oe_n,
    input wire        irq
);
    // ------------------------------------------------------------
    // bus decode helpers
    // ------------------------------------------------------------
    wire [7:0] a8 = haddr[7:0];
    wire       rd = hsel && htrans[1] && hready && !hwrite;
    wire       wr = hsel && htrans[1] && hready && hwrite;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_irq_after_reset: assert property (
        $rose(hresetn) |-> !irq) else $error("irq high after reset");
    a_rx_upper_zero: assert property (
        rd && a8 == `TWS_OFF_RX_HOLD |=> hrdata[31:8] == 24'h000000) else $error("rx upper");
    a_rx_byte_shown: assert property (
        rx_byte_valid ##1 !rx_byte_valid ##1 (rd && a8 == `TWS_OFF_RX_HOLD)
        |=> hrdata[7:0] == $past(received_byte, 3)) else $error("rx byte lost");
    a_status_resv: assert property (
        rd && a8 == `TWS_OFF_STATUS |=> hrdata[31:16] == 16'h0000 && !hrdata[7])
        else $error("status reserved set");
    a_mask_resv: assert property (
        rd && a8 == `TWS_OFF_IRQ_MASK |=> hrdata[31:16] == 16'h0000 && !hrdata[7] && !hrdata[3])
        else $error("mask reserved set");
    a_wo_reads_zero: assert property (
        rd && (a8 == `TWS_OFF_IRQ_SET || a8 == `TWS_OFF_IRQ_CLR) |=> hrdata == 32'h00000000)
        else $error("write-only read nonzero");
    a_thr_byte: assert property (
        tx_hold_written |=> byte_to_send == $past(hwdata[7:0])) else $error("tx byte wrong");
    a_thr_cause: assert property (
        tx_hold_written |-> $past(wr && a8 == `TWS_OFF_TX_HOLD)) else $error("stray tx write");
    a_thr_busy: assert property (
        tx_hold_written && !tx_byte_taken && !not_acknowledged_event |=> !transmit_ready)
        else $error("ready after tx write");
    a_taken_ready: assert property (
        tx_byte_taken && !tx_hold_written |=> transmit_ready) else $error("ready not set");
    a_stretch_slave: assert property (
        !scl_oe_n |-> $past(!master_mode)) else $error("stretch in master mode");
endmodule

bind tws_status_irq tws_sti_checker #(.CNT_W(CNT_W)) tws_sti_checker_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .master_mode, .rx_byte_valid, .received_byte, .tx_byte_taken, .not_acknowledged_event,
    .byte_to_send, .tx_hold_written, .transmit_ready, .scl_oe_n, .irq);

// File: tws_bus_partner.sv
// far-side bus master model driving the shared clock line
`timescale 1ns/100ps

module tws_bus_partner (
    input  wire run,
    input  wire scl_out,
    input  wire scl_oe_n,
    output wire scl_line
);
    reg drive_low = 1'b0;

    // open drain with pull-up: either party can only pull low
    assign scl_line = !drive_low && (scl_oe_n || scl_out);

    // line stands high between frames; a held-low line delays the next phase
    always begin
        wait (run);
        #62.5 drive_low = 1'b1;
        #62.5 drive_low = 1'b0;
        wait (scl_line);
    end
endmodule

// File: tws_status_irq_bench.sv
// self-checking bench of the two-wire status block
`timescale 1ns/100ps
`include "tws_consts.vh"

module tws_status_irq_bench;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        master_mode = 1'b1;
    logic        slave_read = 1'b1;
    logic        run = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [10:0] ev = 11'h000;
    logic [7:0]  rbyte = 8'h00;
    logic [15:0] rc = 16'h0000;
    logic [15:0] rn = 16'h0000;
    logic [15:0] tc = 16'h0000;
    logic [15:0] tn = 16'h0000;
    logic [31:0] s;
    logic [31:0] m;
    logic [31:0] v;
    logic [7:0]  regs [6] = '{`TWS_OFF_IRQ_SET, `TWS_OFF_IRQ_CLR, `TWS_OFF_IRQ_MASK,
                              `TWS_OFF_RX_HOLD, `TWS_OFF_TX_HOLD, 8'h3C};
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    wire         hreadyout, hresp, tx_hold_written, transmit_ready;
    wire         scl_in, scl_out, scl_oe_n, irq;
    wire [31:0]  hrdata;
    wire [7:0]   byte_to_send;

    tws_status_irq #(.CNT_W(16)) tws_status_irq_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .master_mode,
        .frame_start(ev[0]), .frame_done(ev[1]), .arb_lost_event(ev[2]),
        .not_acknowledged_event(ev[3]), .rx_byte_valid(ev[4]), .received_byte(rbyte),
        .tx_byte_taken(ev[5]), .slave_read, .addr_match(ev[6]), .stop_or_not_acknowledged(ev[7]),
        .general_call(ev[8]), .byte_to_send, .tx_hold_written, .transmit_ready,
        .rx_transfer_count(rc), .rx_next_count(rn), .tx_transfer_count(tc),
        .tx_next_count(tn), .rx_count_written(ev[9]), .tx_count_written(ev[10]),
        .scl_in, .scl_out, .scl_oe_n, .irq);

    tws_bus_partner tws_bus_partner_i (.run, .scl_out, .scl_oe_n, .scl_line(scl_in));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; waits on hready, no fixed latency assumed
    task bus(input [7:0] a, input w, input [31:0] d, output [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task pulse(input [10:0] p);
        @(posedge hclk);
        ev <= p;
        @(posedge hclk);
        ev <= 11'h000;
    endtask

    task wait_oe(input logic lvl);
        for (int i = 0; i < 300 && scl_oe_n !== lvl; i++) @(posedge hclk);
        chk(32'(scl_oe_n), 32'(lvl));
    endtask

    function automatic [31:0] cnt_exp(input [15:0] a, b, c, d);
        cnt_exp = {16'h0000, c == 0 && d == 0, a == 0 && b == 0, c == 0, a == 0, 12'h000};
    endfunction

    task conclude;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial forever #4 hclk = ~hclk;

    // hang guard, far above the few hundred cycles the tests take
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        v = $urandom(32'hED8E1068);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s, {16'h0000, `TWS_STATUS_RESET});
        foreach (regs[i]) begin
            bus(regs[i], 1'b0, 32'h0, s);
            chk(s, 32'h00000000);
        end
        $display("reset test done");
        m = 32'h00000000;
        repeat (8) begin
            v = $urandom;
            bus(`TWS_OFF_IRQ_SET, 1'b1, v, s);
            m = m | (v & 32'h0000FF77);
            v = $urandom;
            bus(`TWS_OFF_IRQ_CLR, 1'b1, v, s);
            m = m & ~v;
            bus(`TWS_OFF_IRQ_MASK, 1'b0, 32'h0, s);
            chk(s, m);
        end
        bus(`TWS_OFF_IRQ_CLR, 1'b1, 32'hFFFFFFFF, s);
        $display("mask test done");
        repeat (5) begin
            rc <= 16'($urandom % 3);
            rn <= 16'($urandom % 3);
            tc <= 16'($urandom % 3);
            tn <= 16'($urandom % 3);
            pulse(11'h600);
            bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
            chk(s & 32'h0000F000, cnt_exp(rc, rn, tc, tn));
            rc <= 16'h0000;
            tc <= 16'h0000;
            bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
            chk(s & 32'h0000F000, cnt_exp(16'h0, rn, 16'h0, tn));
        end
        $display("counter test done");
        bus(`TWS_OFF_IRQ_SET, 1'b1, 32'h00000200, s);
        pulse(11'h001);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s & 32'h00000201, 32'h00000000);
        pulse(11'h004);
        @(negedge hclk);
        chk(32'(irq), 32'h1);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s & 32'h00000201, 32'h00000201);
        chk(32'(irq), 32'h0);
        pulse(11'h004);
        bus(`TWS_OFF_IRQ_CLR, 1'b1, 32'h00000200, s);
        @(negedge hclk);
        chk(32'(irq), 32'h0);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s & 32'h00000200, 32'h00000000);
        pulse(11'h001);
        pulse(11'h002);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s & 32'h00000001, 32'h00000001);
        $display("arbitration test done");
        master_mode <= 1'b0;
        slave_read <= 1'b1;
        pulse(11'h060);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s & 32'h00000810, 32'h00000010);
        run <= 1'b1;
        wait_oe(1'b0);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s & 32'h00000400, 32'h00000400);
        v = $urandom;
        bus(`TWS_OFF_TX_HOLD, 1'b1, v, s);
        @(negedge hclk);
        chk(32'(byte_to_send), {24'h000000, v[7:0]});
        wait_oe(1'b1);
        run <= 1'b0;
        pulse(11'h080);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s & 32'h00000C10, 32'h00000800);
        bus(`TWS_OFF_STATUS, 1'b0, 32'h0, s);
        chk(s & 32'h00000800, 32'h00000000);
        bus(`TWS_OFF_TX_HOLD, 1'b0, 32'h0, s);
        chk(s, {24'h000000, v[7:0]});
        $display("slave test done");
        master_mode <= 1'b1;
        repeat (4) begin
            rbyte <= 8'($urandom);
            pulse(11'h010);
            bus(`TWS_OFF_RX_HOLD, 1'b0, 32'h0, s);
            chk(s, {24'h000000, rbyte});
        end
        $display("holding test done");
        conclude();
    end
endmodule
